/* File: src/osp_regs.svh */
// Operation
// (RL1) answer only bus address 0x57 sent msb first; bytes 0xAE and 0xAF
// (RL2) address byte lsb selects direction: 0 write, 1 read
// (RL3) compare address bit by bit, drop out on the first mismatch
// (RL4) after a matching address, pull data low for one clock
// (RL5) every byte is 8 bits plus a ninth acknowledge clock
// (RL6) in writes, hold data low for the whole ninth clock
// (RL7) master acks each read byte, nacks the last then stops
// (RL8) start is data falling with clock high, stop data rising
// (RL9) master keeps data stable while clock high except start/stop
// (RL10) stop accepted anywhere; not in the same high pulse as start (the code accepts a stop there too)
// (RL11) repeated start keeps transaction alive for a new address
// (RL12) write is address, index byte, data; pointer advances per byte
// (RL13) read: index write, repeated start, read address, auto-increment
// (RL14) sample-queue data register reads do not advance the pointer
// (RL15) works with master bus clocks up to 400 kHz
// (RL16) clock is input only; data is open drain and sampled
// (RL17) host enters heart-rate mode with mode 0x02, masks sample ready
// (RL18) sample queue holds up to 32 samples
// (RL19) heart-rate mode: almost-full when exactly one entry is empty
// (RL20) after draining, next sample lands at the read pointer slot
// (RL21) power-ready interrupt raised, cleared by reading status
// (RL22) heart-rate mode takes red or infrared channel as source
// (RL23) interrupt pin active low open drain while enabled flag pending
// (RL24) after master nack, release data and wait for stop or start
`ifndef OSP_REGS_SVH
`define OSP_REGS_SVH

// ==========================================================
// bus address and register offsets
`define OSP_DEV_ADDR      7'h57
`define OSP_REG_STATUS    8'h00
`define OSP_REG_ENABLE    8'h02
`define OSP_REG_FIFO_DATA 8'h07
`define OSP_REG_MODE      8'h09
`define OSP_REG_CHAN      8'h0A

// ==========================================================
// field positions, values and reset values
`define OSP_BIT_AFULL     3
`define OSP_BIT_SRDY      6
`define OSP_BIT_PRDY      0
`define OSP_BIT_AFULL_EN  7
`define OSP_MODE_HR       3'h2
`define OSP_ENABLE_RST    8'h00
`define OSP_MODE_RST      3'h0
`define OSP_QUEUE_DEPTH   32
`define OSP_SAMPLE_W      18
`define OSP_BUS_MAX_KHZ   400

`endif

/* File: src/osp_pkg.sv */
package osp_pkg;

	// ==========================================================
	// link state machine
	typedef enum logic [7:0] {
		OSP_IDLE  = 8'h01,
		OSP_ADDR  = 8'h02,
		OSP_ACK_A = 8'h04,
		OSP_RX    = 8'h08,
		OSP_ACK_W = 8'h10,
		OSP_TX    = 8'h20,
		OSP_ACK_R = 8'h40,
		OSP_HOLD  = 8'h80
	} osp_state_type;

	// ==========================================================
	// byte operations passed to the core
	typedef enum logic [1:0] {
		OSP_OP_INDEX = 2'h0,
		OSP_OP_WRITE = 2'h1,
		OSP_OP_READ  = 2'h2
	} osp_op_type;

endpackage : osp_pkg

/* File: src/osp_slave_port.sv */
`timescale 1ns/1ps
`include "osp_regs.svh"

module osp_slave_port #(
	parameter int DEPTH    = `OSP_QUEUE_DEPTH,
	parameter int SAMPLE_W = `OSP_SAMPLE_W
) (
	input  wire logic                CORE_CLK_IN,
	input  wire logic                LINK_CLK_IN,
	input  wire logic                RST_B_IN,
	input  wire logic                SCL_IN,
	input  wire logic                SDA_IN,
	output logic                     SDA_OUT,
	output logic                     SDA_OE_B_OUT,
	output logic                     INT_OUT,
	output logic                     INT_OE_B_OUT,
	input  wire logic                POWER_GOOD_IN,
	input  wire logic                SAMPLE_STROBE_IN,
	input  wire logic [SAMPLE_W-1:0] RED_SAMPLE_IN,
	input  wire logic [SAMPLE_W-1:0] IR_SAMPLE_IN,
	output logic [2:0]               MODE_OUT,
	output logic                     IR_SELECT_OUT,
	output logic [$clog2(DEPTH):0]   QUEUE_LEVEL_OUT
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [6:0] DEV_ADDR = `OSP_DEV_ADDR;

	// ==========================================================
	// link side: pin synchronisers and bus events
	logic                   scl_m;
	logic                   scl_s;
	logic                   scl_d;
	logic                   sda_m;
	logic                   sda_s;
	logic                   sda_d;
	osp_pkg::osp_state_type state;
	osp_pkg::osp_state_type next_state;
	logic [3:0]             bitcnt;
	logic [3:0]             next_bitcnt;
	logic [7:0]             shreg;
	logic [7:0]             next_shreg;
	logic                   sda_oe_b;
	logic                   next_oe_b;
	logic                   rw;
	logic                   next_rw;
	logic                   idx_next;
	logic                   next_idx;
	logic                   issue;
	osp_pkg::osp_op_type    issue_op;
	logic                   req_t;
	osp_pkg::osp_op_type    link_op;
	logic [7:0]             link_data;
	logic                   ack_m;
	logic                   ack_s;
	logic                   ack_d;
	logic [7:0]             tx_byte;
	logic [7:0]             rdata;
	logic                   ack_t;

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start    = scl_s & scl_d & sda_d & ~sda_s; // RL8
	wire stop     = scl_s & scl_d & ~sda_d & sda_s; // RL8 RL10
	wire addr_bit = DEV_ADDR[3'(3'h6 - bitcnt[2:0])]; // RL1
	wire ack_evt  = ack_s ^ ack_d;

	// oversampled at link rate, far above the bus clock RL15
	always_ff @(posedge LINK_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_d} <= {SCL_IN, scl_m, scl_s}; // RL16
			{sda_m, sda_s, sda_d} <= {SDA_IN, sda_m, sda_s}; // RL16
		end
	end

	// ==========================================================
	// link state machine
	always_comb begin
		next_state  = state;
		next_bitcnt = bitcnt;
		next_shreg  = shreg;
		next_oe_b   = sda_oe_b;
		next_rw     = rw;
		next_idx    = idx_next;
		issue       = 1'b0;
		issue_op    = osp_pkg::OSP_OP_READ;
		if (stop) begin
			next_state = osp_pkg::OSP_IDLE; // RL10
			next_oe_b  = 1'b1;
		end else if (start) begin
			next_state  = osp_pkg::OSP_ADDR; // RL11
			next_bitcnt = 4'h0;
			next_oe_b   = 1'b1;
		end else begin
			case (state)
				osp_pkg::OSP_ADDR: begin
					if (scl_rise) begin
						next_shreg  = {shreg[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
						if (bitcnt < 4'h7 && sda_s != addr_bit)
							next_state = osp_pkg::OSP_HOLD; // RL3
						if (bitcnt == 4'h7)
							next_rw = sda_s; // RL2
					end else if (scl_fall && bitcnt == 4'h8) begin
						next_state = osp_pkg::OSP_ACK_A;
						next_oe_b  = 1'b0; // RL4
						issue      = rw; // RL13
					end
				end
				osp_pkg::OSP_ACK_A: begin
					if (scl_fall) begin
						if (rw) begin
							next_state  = osp_pkg::OSP_TX;
							next_shreg  = tx_byte;
							next_oe_b   = tx_byte[7];
							next_bitcnt = 4'h1;
						end else begin
							next_state  = osp_pkg::OSP_RX;
							next_oe_b   = 1'b1;
							next_bitcnt = 4'h0;
							next_idx    = 1'b1; // RL12
						end
					end
				end
				osp_pkg::OSP_RX: begin
					if (scl_rise) begin
						next_shreg  = {shreg[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						next_state = osp_pkg::OSP_ACK_W; // RL5
						next_oe_b  = 1'b0; // RL6
						issue      = 1'b1;
						issue_op   = idx_next ? osp_pkg::OSP_OP_INDEX
						                      : osp_pkg::OSP_OP_WRITE; // RL12
						next_idx   = 1'b0;
					end
				end
				osp_pkg::OSP_ACK_W: begin
					if (scl_fall) begin
						next_state  = osp_pkg::OSP_RX;
						next_oe_b   = 1'b1;
						next_bitcnt = 4'h0;
					end
				end
				osp_pkg::OSP_TX: begin
					if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							next_state = osp_pkg::OSP_ACK_R; // RL5
							next_oe_b  = 1'b1;
						end else begin
							next_oe_b   = shreg[6];
							next_shreg  = {shreg[6:0], 1'b0};
							next_bitcnt = bitcnt + 4'h1;
						end
					end
				end
				osp_pkg::OSP_ACK_R: begin
					if (scl_rise) begin
						if (sda_s)
							next_state = osp_pkg::OSP_HOLD; // RL24 RL7
						else
							issue = 1'b1; // RL13
					end else if (scl_fall) begin
						next_state  = osp_pkg::OSP_TX;
						next_shreg  = tx_byte;
						next_oe_b   = tx_byte[7];
						next_bitcnt = 4'h1;
					end
				end
				osp_pkg::OSP_IDLE: ;
				osp_pkg::OSP_HOLD: ;
				default: next_state = osp_pkg::OSP_IDLE;
			endcase
		end
	end

	always_ff @(posedge LINK_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state    <= osp_pkg::OSP_IDLE;
			bitcnt   <= 4'h0;
			shreg    <= 8'h00;
			sda_oe_b <= 1'b1;
			rw       <= 1'b0;
			idx_next <= 1'b0;
		end else begin
			state    <= next_state;
			bitcnt   <= next_bitcnt;
			shreg    <= next_shreg;
			sda_oe_b <= next_oe_b;
			rw       <= next_rw;
			idx_next <= next_idx;
		end
	end

	// ==========================================================
	// link to core handshake: toggle plus held word
	always_ff @(posedge LINK_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			req_t     <= 1'b0;
			link_op   <= osp_pkg::OSP_OP_READ;
			link_data <= 8'h00;
		end else if (issue) begin
			req_t     <= ~req_t;
			link_op   <= issue_op;
			link_data <= shreg;
		end
	end

	always_ff @(posedge LINK_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			{ack_m, ack_s, ack_d} <= 3'h0;
			tx_byte               <= 8'h00;
		end else begin
			{ack_m, ack_s, ack_d} <= {ack_t, ack_m, ack_s};
			if (ack_evt)
				tx_byte <= rdata;
		end
	end

	assign SDA_OUT      = 1'b0;
	assign SDA_OE_B_OUT = sda_oe_b; // RL16

	// ==========================================================
	// core side: request capture
	logic                req_m;
	logic                req_s;
	logic                req_d;
	logic [7:0]          ptr;
	logic [7:0]          enable;
	logic [2:0]          mode;
	logic                ir_sel;
	logic                afull;
	logic                srdy;
	logic                prdy;
	logic                pg_m;
	logic                pg_s;
	logic                pg_d;
	logic                irq_any_q;
	logic [SAMPLE_W-1:0] queue [DEPTH];
	logic [AW-1:0]       wr_ptr;
	logic [AW-1:0]       rd_ptr;
	logic [AW:0]         count;
	logic [1:0]          byte_sel;

	function automatic logic [7:0] osp_read_mux(
		input logic [7:0] addr,
		input logic [7:0] status,
		input logic [7:0] en,
		input logic [2:0] md,
		input logic       chan,
		input logic [7:0] qbyte
	);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			`OSP_REG_STATUS:    val = status;
			`OSP_REG_ENABLE:    val = en;
			`OSP_REG_FIFO_DATA: val = qbyte;
			`OSP_REG_MODE:      val = {5'h00, md};
			`OSP_REG_CHAN:      val = {7'h00, chan};
			default:            val = 8'h00;
		endcase
		return val;
	endfunction : osp_read_mux

	wire        req_evt   = req_s ^ req_d;
	wire        is_read   = req_evt && link_op == osp_pkg::OSP_OP_READ;
	wire        is_write  = req_evt && link_op == osp_pkg::OSP_OP_WRITE;
	wire        is_index  = req_evt && link_op == osp_pkg::OSP_OP_INDEX;
	wire        at_fifo   = ptr == `OSP_REG_FIFO_DATA;
	wire        rd_status = is_read && ptr == `OSP_REG_STATUS;
	wire        rd_fifo   = is_read && at_fifo;
	wire        q_empty   = count == '0;
	wire        q_full    = count == (AW+1)'(DEPTH);
	wire        pop       = rd_fifo && byte_sel == 2'h2 && !q_empty;
	wire        push      = SAMPLE_STROBE_IN && mode == `OSP_MODE_HR
	                        && !q_full; // RL17 RL18
	wire        af_set    = push && !pop
	                        && count == (AW+1)'(DEPTH - 2); // RL19
	wire        pg_rise   = pg_s & ~pg_d;
	wire [23:0] q_word    = q_empty ? 24'h000000
	                                : 24'(queue[rd_ptr]);
	wire [7:0]  q_byte    = byte_sel == 2'h0 ? q_word[23:16]
	                      : byte_sel == 2'h1 ? q_word[15:8]
	                                         : q_word[7:0];
	wire [7:0]  status    = (8'(afull) << `OSP_BIT_AFULL)
	                      | (8'(srdy) << `OSP_BIT_SRDY)
	                      | (8'(prdy) << `OSP_BIT_PRDY);
	wire [7:0]  rd_val    = osp_read_mux(ptr, status, enable, mode,
	                                     ir_sel, q_byte);
	wire [SAMPLE_W-1:0] src = ir_sel ? IR_SAMPLE_IN : RED_SAMPLE_IN; // RL22
	wire        irq_any   = (afull & enable[`OSP_BIT_AFULL_EN])
	                      | (srdy & enable[`OSP_BIT_SRDY]) | prdy;

	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			{req_m, req_s, req_d} <= 3'h0;
			{pg_m, pg_s, pg_d}    <= 3'h0;
		end else begin
			{req_m, req_s, req_d} <= {req_t, req_m, req_s};
			{pg_m, pg_s, pg_d}    <= {POWER_GOOD_IN, pg_m, pg_s};
		end
	end

	// ==========================================================
	// register pointer and answers
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ptr   <= 8'h00;
			rdata <= 8'h00;
			ack_t <= 1'b0;
		end else if (req_evt) begin
			ack_t <= ~ack_t;
			if (is_index)
				ptr <= link_data; // RL12
			else if (is_write || (is_read && !at_fifo))
				ptr <= ptr + 8'h01; // RL12 RL13
			if (is_read)
				rdata <= rd_val; // RL14
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			enable <= `OSP_ENABLE_RST;
			mode   <= `OSP_MODE_RST;
			ir_sel <= 1'b0;
		end else if (is_write) begin
			if (ptr == `OSP_REG_ENABLE)
				enable <= link_data;
			if (ptr == `OSP_REG_MODE)
				mode <= link_data[2:0]; // RL17
			if (ptr == `OSP_REG_CHAN)
				ir_sel <= link_data[0]; // RL22
		end
	end

	// ==========================================================
	// status flags, set wins over read clear
	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			afull     <= 1'b0;
			srdy      <= 1'b0;
			prdy      <= 1'b0;
			irq_any_q <= 1'b0;
		end else begin
			afull     <= af_set | (afull & ~rd_status); // RL19
			srdy      <= push | (srdy & ~rd_status);
			prdy      <= pg_rise | (prdy & ~rd_status); // RL21
			irq_any_q <= irq_any; // RL23
		end
	end

	assign INT_OUT      = 1'b0;
	assign INT_OE_B_OUT = ~irq_any_q; // RL23

	// ==========================================================
	// sample queue, circular
	always_ff @(posedge CORE_CLK_IN) begin
		if (push)
			queue[wr_ptr] <= src; // RL20
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			byte_sel <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + AW'(1); // RL20
			if (pop)
				rd_ptr <= rd_ptr + AW'(1);
			count <= count + (AW+1)'(push) - (AW+1)'(pop); // RL18
			if (rd_fifo)
				byte_sel <= byte_sel == 2'h2 ? 2'h0 : byte_sel + 2'h1;
		end
	end

	assign MODE_OUT        = mode;
	assign IR_SELECT_OUT   = ir_sel;
	assign QUEUE_LEVEL_OUT = count;

	// ==========================================================
	// checks
	a_addr_mismatch: assert property ( // RL3
		@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
		state == osp_pkg::OSP_ADDR && scl_rise && !start && !stop
		&& bitcnt < 4'h7 && sda_s != addr_bit
		|=> state == osp_pkg::OSP_HOLD)
		else $error("address mismatch not dropped");

	a_addr_ack_low: assert property ( // RL4
		@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
		state == osp_pkg::OSP_ACK_A |-> !sda_oe_b)
		else $error("address ack not driven");

	a_write_ack_low: assert property ( // RL6
		@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
		$rose(state == osp_pkg::OSP_ACK_W) |->
		!sda_oe_b throughout (state == osp_pkg::OSP_ACK_W)[*2])
		else $error("write ack released early");

	a_byte_nine: assert property ( // RL5
		@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
		state == osp_pkg::OSP_RX && scl_fall && !stop && !start
		&& bitcnt == 4'h8 |=> state == osp_pkg::OSP_ACK_W)
		else $error("ninth clock not acked");

	a_stop_idle: assert property ( // RL10
		@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
		stop |=> state == osp_pkg::OSP_IDLE && sda_oe_b)
		else $error("stop not honoured");

	a_restart_addr: assert property ( // RL11
		@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
		start && !stop |=> state == osp_pkg::OSP_ADDR && bitcnt == 4'h0)
		else $error("start not honoured");

	a_nack_release: assert property ( // RL24
		@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
		state == osp_pkg::OSP_ACK_R && scl_rise && sda_s && !stop
		&& !start |=> state == osp_pkg::OSP_HOLD && sda_oe_b)
		else $error("nack not released");

	a_fifo_ptr_hold: assert property ( // RL14
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		rd_fifo |=> ptr == $past(ptr))
		else $error("pointer moved on queue read");

	a_ptr_advance: assert property ( // RL12
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		is_write |=> ptr == 8'($past(ptr) + 8'h01))
		else $error("pointer not advanced");

	a_almost_full: assert property ( // RL19
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		push && !pop && count == (AW+1)'(DEPTH - 2)
		|=> afull && count == (AW+1)'(DEPTH - 1))
		else $error("almost full missed");

	a_power_clear: assert property ( // RL21
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		rd_status && !pg_rise |=> !prdy)
		else $error("power ready not cleared");

	a_int_pin: assert property ( // RL23
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		prdy |=> !INT_OE_B_OUT)
		else $error("interrupt pin not low");

	a_queue_bound: assert property ( // RL18
		@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
		count <= (AW+1)'(DEPTH))
		else $error("queue overflow");

endmodule : osp_slave_port

/* File: verification/osp_bus_master.sv */
`timescale 1ns/1ps

// ==========================================================
// bus master model: drives the clock, pulls data low or lets go
module osp_bus_master (
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	int ph = 250;

	initial begin
		scl_out     = 1'b1;
		sda_low_out = 1'b0;
	end

	// ==========================================================
	// one clock pulse, data only moves while the clock is low
	task automatic pulse(input logic low, output logic s1, output logic s2);
		#(ph) sda_low_out = low;
		#(ph) scl_out = 1'b1;
		s1 = sda_in;
		#(2 * ph) s2 = sda_in;
		scl_out = 1'b0;
	endtask : pulse

	task automatic bus_start;
		#(ph) sda_low_out = 1'b0;
		#(ph) scl_out = 1'b1;
		#(ph) sda_low_out = 1'b1;
		#(ph) scl_out = 1'b0;
	endtask : bus_start

	task automatic bus_stop;
		#(ph) sda_low_out = 1'b1;
		#(ph) scl_out = 1'b1;
		#(ph) sda_low_out = 1'b0;
		#(ph);
	endtask : bus_stop

	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s1;
		logic s2;
		for (int i = 7; i >= 0; i--) begin
			pulse(!b[i], s1, s2);
		end
		pulse(1'b0, s1, s2);
		ack = (s1 === 1'b0) && (s2 === 1'b0);
	endtask : wr_byte

	task automatic rd_byte(input logic last, output logic [7:0] b);
		logic s1;
		logic s2;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b0, s1, s2);
			b[i] = s2;
		end
		pulse(!last, s1, s2);
	endtask : rd_byte
endmodule : osp_bus_master

/* File: verification/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
	typedef struct {
		logic [7:0] idx;
		logic [7:0] wr;
		logic [7:0] exp;
	} osp_row_type;

	localparam int LIMIT = 96000;
	logic        core_clk        = 1'b0;
	logic        link_clk        = 1'b0;
	logic        rst_b           = 1'b0;
	logic        power_good      = 1'b0;
	logic        strobe          = 1'b0;
	logic [17:0] red             = 18'h00000;
	logic [17:0] ir              = 18'h00000;
	logic        scl;
	logic        sda_low;
	logic        sda_oe_b;
	logic        int_oe_b;
	logic        ir_sel;
	logic [2:0]  mode;
	logic [5:0]  level;
	wire         sda;
	logic        sda_out;
	logic        int_out;
	wire         int_line;
	int          fails           = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	logic [7:0]  rd_q[$];
	logic        ack;
	logic [7:0]  bad [2]         = '{8'hAC, 8'h2E};
	osp_row_type rows [6]        = '{'{8'h09, 8'h02, 8'h02},
		'{8'h0A, 8'h01, 8'h01}, '{8'h0A, 8'h00, 8'h00},
		'{8'h02, 8'h80, 8'h80}, '{8'h05, 8'hFF, 8'h00},
		'{8'h09, 8'h00, 8'h00}};

	// ==========================================================
	// clocks, wire and instances
	always #5 core_clk = ~core_clk;

	initial begin
		#3.7;
		forever #24 link_clk = ~link_clk;
	end

	assign sda = (sda_low || (!sda_oe_b && !sda_out)) ? 1'b0 : 1'b1;
	assign int_line = (!int_oe_b && !int_out) ? 1'b0 : 1'b1;

	osp_bus_master m (
		.sda_in      (sda),
		.scl_out     (scl),
		.sda_low_out (sda_low)
	);

	osp_slave_port DUT (
		.CORE_CLK_IN      (core_clk),
		.LINK_CLK_IN      (link_clk),
		.RST_B_IN         (rst_b),
		.SCL_IN           (scl),
		.SDA_IN           (sda),
		.SDA_OUT          (sda_out),
		.SDA_OE_B_OUT     (sda_oe_b),
		.INT_OUT          (int_out),
		.INT_OE_B_OUT     (int_oe_b),
		.POWER_GOOD_IN    (power_good),
		.SAMPLE_STROBE_IN (strobe),
		.RED_SAMPLE_IN    (red),
		.IR_SAMPLE_IN     (ir),
		.MODE_OUT         (mode),
		.IR_SELECT_OUT    (ir_sel),
		.QUEUE_LEVEL_OUT  (level)
	);

	// ==========================================================
	// shared tasks
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [23:0] seen,
		input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic reg_write(input logic [7:0] idx, input logic [7:0] d[$]);
		m.bus_start();
		m.wr_byte(8'hAE, ack);
		check("write address ack", ack, 1'b1);
		m.wr_byte(idx, ack);
		check("index ack", ack, 1'b1);
		foreach (d[i]) begin
			m.wr_byte(d[i], ack);
			check("data ack", ack, 1'b1);
		end
		m.bus_stop();
	endtask : reg_write

	task automatic reg_read(input logic [7:0] idx, input int n);
		logic [7:0] b;
		rd_q = {};
		m.bus_start();
		m.wr_byte(8'hAE, ack);
		m.wr_byte(idx, ack);
		m.bus_start();
		m.wr_byte(8'hAF, ack);
		check("read address ack", ack, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.rd_byte(i == n - 1, b);
			rd_q.push_back(b);
		end
		m.bus_stop();
		check("data line free", sda, 1'b1);
	endtask : reg_read

	task automatic push(input logic [17:0] r, input logic [17:0] i);
		@(posedge core_clk);
		#1;
		strobe = 1'b1;
		red = r;
		ir = i;
		@(posedge core_clk);
		#1;
		strobe = 1'b0;
	endtask : push

	// ==========================================================
	// main sequence
	initial begin
		cyc(10);
		rst_b = 1'b1;
		check("oe after reset", sda_oe_b, 1'b1);
		check("int after reset", int_oe_b, 1'b1);
		check("mode after reset", mode, 3'h0);
		check("level after reset", level, 6'h00);
		cyc(30);
		foreach (rows[k]) begin
			reg_write(rows[k].idx, '{rows[k].wr});
			reg_read(rows[k].idx, 1);
			check("row readback", rd_q[0], rows[k].exp);
		end
		push(18'h00001, 18'h00002);
		cyc(2);
		check("level outside mode", level, 6'h00);
		foreach (bad[k]) begin
			m.bus_start();
			m.wr_byte(bad[k], ack);
			check("foreign address ack", ack, 1'b0);
			m.bus_stop();
		end
		reg_write(8'h09, '{8'h02, 8'h01});
		check("mode", mode, 3'h2);
		check("channel", ir_sel, 1'b1);
		m.ph = 625;
		reg_read(8'h09, 2);
		m.ph = 250;
		check("burst byte 0", rd_q[0], 8'h02);
		check("burst byte 1", rd_q[1], 8'h01);
		power_good = 1'b1;
		cyc(8);
		check("int on power ready", int_oe_b, 1'b0);
		reg_read(8'h00, 1);
		check("power ready flag", rd_q[0][0], 1'b1);
		cyc(4);
		check("int after status read", int_oe_b, 1'b1);
		reg_write(8'h0A, '{8'h00});
		push(18'h2A5A5, 18'h15A5A);
		reg_write(8'h0A, '{8'h01});
		push(18'h3C3C3, 18'h01234);
		reg_read(8'h07, 6);
		check("red sample", {rd_q[0], rd_q[1], rd_q[2]}, 24'h02A5A5);
		check("ir sample", {rd_q[3], rd_q[4], rd_q[5]}, 24'h001234);
		check("drained", level, 6'h00);
		push(18'h00FFF, 18'h2BEEF);
		reg_read(8'h07, 3);
		check("after drain", {rd_q[0], rd_q[1], rd_q[2]}, 24'h02BEEF);
		for (int k = 0; k < 30; k++) begin
			push(18'(k), 18'(k));
		end
		cyc(4);
		check("level 30", level, 6'd30);
		check("int at two free", int_oe_b, 1'b1);
		push(18'h00100, 18'h00200);
		cyc(3);
		check("level 31", level, 6'd31);
		check("int at one free", int_oe_b, 1'b0);
		reg_read(8'h00, 1);
		check("almost full flag", rd_q[0][3], 1'b1);
		cyc(4);
		check("int cleared", int_oe_b, 1'b1);
		push(18'h00300, 18'h00400);
		push(18'h00500, 18'h00600);
		cyc(3);
		check("level full", level, 6'd32);
		// mid-run reset with power good still high
		rst_b = 1'b0;
		cyc(10);
		check("oe in reset", sda_oe_b, 1'b1);
		check("mode in reset", mode, 3'h0);
		check("channel in reset", ir_sel, 1'b0);
		check("level in reset", level, 6'h00);
		check("int line in reset", int_line, 1'b1);
		rst_b = 1'b1;
		cyc(8);
		check("int at release", int_oe_b, 1'b0);
		check("int line at release", int_line, 1'b0);
		cyc(22);
		reg_write(8'h09, '{8'h02});
		check("mode written after reset", mode, 3'h2);
		finish_test();
	end
endmodule : tb_top
